// *** ttm_pkg.sv ***
// Shared constants and types for the TDM transmit slot-mask block.
// Assumes a 32-bit APB register bus with byte addresses on 8 bits.
package ttm_pkg;

  // Default widths
  localparam int unsigned TTM_DATA_W = 16;
  localparam int unsigned TTM_SLOTS = 32;
  localparam int unsigned TTM_ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] TTM_OFF_CTRL = 8'h00;
  localparam logic [7:0] TTM_OFF_MASK = 8'h04;
  localparam logic [7:0] TTM_OFF_TXDATA = 8'h08;
  localparam logic [7:0] TTM_OFF_SKIP = 8'h0c;
  localparam logic [7:0] TTM_OFF_STATUS = 8'h10;
  localparam logic [7:0] TTM_OFF_CLEAR = 8'h14;
  localparam logic [7:0] TTM_OFF_INTEN = 8'h18;
  localparam logic [7:0] TTM_OFF_WORD = 8'h1c;

  // Field positions
  localparam int unsigned TTM_ST_EMPTY = 0;
  localparam int unsigned TTM_ST_UNDERRUN = 1;
  localparam int unsigned TTM_WLEN_W = 4;

  // Control bits, lowest first: enable, invert, length select, early sync
  typedef struct packed {
    logic early_frame_sync;
    logic frame_sync_length_sel;
    logic frame_sync_invert;
    logic enable;
  } ttm_ctrl_s;

  typedef struct packed {
    logic tx_underrun_flag;
    logic tx_empty_flag;
  } ttm_stat_s;

  typedef enum logic {
    LNK_IDLE,
    LNK_RUN
  } ttm_link_e;

  // Values after reset
  localparam logic [3:0] TTM_CTRL_RST = 4'h0;
  localparam logic [1:0] TTM_STAT_RST = 2'h0;
  localparam logic [1:0] TTM_INTEN_RST = 2'h0;
  localparam logic [3:0] TTM_WLEN_RST = 4'h7;
  localparam logic [31:0] TTM_MASK_RST = 32'hffffffff;

endpackage : ttm_pkg

// *** ttm_tx_slot_mask.sv ***
// Transmit side of a TDM serial port with a per-slot transmit mask.
// Assumes bit clock and frame sync arrive asynchronously and run well below
// core clock / 4; APB master follows the standard two-phase protocol.
`timescale 1ns/1ps
`default_nettype none

module ttm_tx_slot_mask
  import ttm_pkg::*;
#(
  parameter int unsigned DATA_W = TTM_DATA_W,
  parameter int unsigned SLOTS = TTM_SLOTS
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [TTM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Serial link
  input wire logic i_tx_bit_clock,
  input wire logic i_tx_frame_sync,
  output logic o_serial_tx_data_pin_o,
  output logic o_serial_tx_data_pin_oe,
  // Interrupt
  output logic o_irq
);

  localparam int unsigned SLOT_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;

  function automatic logic reg_mapped(input logic [TTM_ADDR_W-1:0] a);
    reg_mapped = (a == TTM_OFF_CTRL) || (a == TTM_OFF_MASK) || (a == TTM_OFF_TXDATA) ||
                 (a == TTM_OFF_SKIP) || (a == TTM_OFF_STATUS) || (a == TTM_OFF_CLEAR) ||
                 (a == TTM_OFF_INTEN) || (a == TTM_OFF_WORD);
  endfunction : reg_mapped

  // MSB-first: place a word of wlen+1 bits at the top of the shifter
  function automatic logic [DATA_W-1:0] align_word(input logic [DATA_W-1:0] d,
                                                   input logic [TTM_WLEN_W-1:0] wlen);
    logic [DATA_W-1:0] r;
    r = d << (DATA_W - 1 - 32'(wlen));
    align_word = r;
  endfunction : align_word

  // Register state
  ttm_ctrl_s ctrl_r, ctrl_nxt;
  ttm_stat_s stat_r, stat_nxt;
  logic [SLOTS-1:0] mask_r, mask_nxt;
  logic [DATA_W-1:0] data_r, data_nxt;
  logic [1:0] inten_r, inten_nxt;
  logic [TTM_WLEN_W-1:0] wlen_r, wlen_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  // Link state
  ttm_link_e state_r, state_nxt;
  logic [SLOT_W-1:0] slot_r, slot_nxt;
  logic [TTM_WLEN_W-1:0] bit_r, bit_nxt;
  logic [DATA_W-1:0] shift_r, shift_nxt;
  logic sd_r, sd_nxt;
  logic oe_r, oe_nxt;
  logic serviced_r, serviced_nxt;
  logic skip_r, skip_nxt;
  logic fs_prev_r, fs_prev_nxt;
  logic frame_pend_r, frame_pend_nxt;

  // Synchronisers
  logic bck_s1_r, bck_s2_r, bck_s3_r;
  logic fs_s1_r, fs_s2_r;

  // Bus decode
  logic acc_wr;
  logic data_wr;
  logic skip_wr;
  logic clr_wr;
  logic [TTM_WLEN_W-1:0] wlen_eff;

  // Link events
  logic bck_rise;
  logic fs_lvl;
  logic fs_start;
  logic word_start;
  logic [SLOT_W-1:0] next_slot;
  logic empty_set;
  logic underrun_set;

  assign acc_wr = i_psel && i_penable && i_pwrite && reg_mapped(i_paddr);
  assign data_wr = acc_wr && (i_paddr == TTM_OFF_TXDATA);
  assign skip_wr = acc_wr && (i_paddr == TTM_OFF_SKIP);
  assign clr_wr = acc_wr && (i_paddr == TTM_OFF_CLEAR);

  // Word length cannot exceed the shifter
  assign wlen_eff = (32'(wlen_r) > DATA_W - 1) ? TTM_WLEN_W'(DATA_W - 1) : wlen_r;

  // Synchronisers: only the second and third stages feed logic
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bck_s1_r <= 1'b0;
      bck_s2_r <= 1'b0;
      bck_s3_r <= 1'b0;
      fs_s1_r <= 1'b0;
      fs_s2_r <= 1'b0;
    end else if (i_clk_en) begin
      bck_s1_r <= i_tx_bit_clock;
      bck_s2_r <= bck_s1_r;
      bck_s3_r <= bck_s2_r;
      fs_s1_r <= i_tx_frame_sync;
      fs_s2_r <= fs_s1_r;
    end
  end

  assign bck_rise = bck_s2_r && !bck_s3_r;
  assign fs_lvl = fs_s2_r ^ ctrl_r.frame_sync_invert;
  // Word- and bit-length sync share the same rising-edge detection
  assign fs_start = bck_rise && fs_lvl && !fs_prev_r;

  // Link next state
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    sd_nxt = sd_r;
    oe_nxt = oe_r;
    serviced_nxt = serviced_r;
    skip_nxt = skip_r;
    fs_prev_nxt = fs_prev_r;
    frame_pend_nxt = frame_pend_r;
    word_start = 1'b0;
    next_slot = slot_r;
    empty_set = 1'b0;
    underrun_set = 1'b0;

    if (!ctrl_r.enable) begin
      state_nxt = LNK_IDLE;
      oe_nxt = 1'b0;
      frame_pend_nxt = 1'b0;
      fs_prev_nxt = 1'b0;
    end else if (bck_rise) begin
      fs_prev_nxt = fs_lvl;
      if (frame_pend_r) begin
        // Early sync: frame begins one bit after the sync edge
        frame_pend_nxt = 1'b0;
        word_start = 1'b1;
        next_slot = '0;
      end else if (fs_start && !ctrl_r.early_frame_sync) begin
        word_start = 1'b1;
        next_slot = '0;
      end else if (state_r == LNK_RUN && bit_r == wlen_eff) begin
        word_start = 1'b1;
        next_slot = slot_r + SLOT_W'(1);
      end else if (state_r == LNK_RUN) begin
        bit_nxt = bit_r + TTM_WLEN_W'(1);
        shift_nxt = shift_r << 1;
        sd_nxt = shift_r[DATA_W-2];
      end
      if (fs_start && ctrl_r.early_frame_sync) begin
        frame_pend_nxt = 1'b1;
      end

      if (word_start) begin
        state_nxt = LNK_RUN;
        bit_nxt = '0;
        slot_nxt = next_slot;
        if (mask_r[next_slot]) begin
          empty_set = 1'b1;
          if (serviced_r && skip_r) begin
            oe_nxt = 1'b0;
          end else begin
            oe_nxt = 1'b1;
            shift_nxt = align_word(data_r, wlen_eff);
            sd_nxt = shift_nxt[DATA_W-1];
            underrun_set = !serviced_r;
          end
          serviced_nxt = 1'b0;
          skip_nxt = 1'b0;
        end else begin
          oe_nxt = 1'b0;
        end
      end
    end

    // A write in the boundary cycle counts for the following slot
    if (data_wr) begin
      serviced_nxt = 1'b1;
      skip_nxt = 1'b0;
    end else if (skip_wr) begin
      serviced_nxt = 1'b1;
      skip_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= LNK_IDLE;
      slot_r <= '0;
      bit_r <= '0;
      shift_r <= '0;
      sd_r <= 1'b0;
      oe_r <= 1'b0;
      serviced_r <= 1'b0;
      skip_r <= 1'b0;
      fs_prev_r <= 1'b0;
      frame_pend_r <= 1'b0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      sd_r <= sd_nxt;
      oe_r <= oe_nxt;
      serviced_r <= serviced_nxt;
      skip_r <= skip_nxt;
      fs_prev_r <= fs_prev_nxt;
      frame_pend_r <= frame_pend_nxt;
    end
  end

  // Register file next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    data_nxt = data_r;
    inten_nxt = inten_r;
    wlen_nxt = wlen_r;
    stat_nxt = stat_r;
    prdata_nxt = prdata_r;

    if (acc_wr) begin
      unique case (i_paddr)
        TTM_OFF_CTRL: ctrl_nxt = ttm_ctrl_s'(i_pwdata[3:0]);
        TTM_OFF_MASK: mask_nxt = i_pwdata[SLOTS-1:0];
        TTM_OFF_TXDATA: data_nxt = i_pwdata[DATA_W-1:0];
        TTM_OFF_INTEN: inten_nxt = i_pwdata[1:0];
        TTM_OFF_WORD: wlen_nxt = i_pwdata[TTM_WLEN_W-1:0];
        default: ;
      endcase
    end

    // Clears first, so a same-cycle hardware set wins
    if (clr_wr) begin
      stat_nxt = ttm_stat_s'(2'(stat_r) & ~i_pwdata[1:0]);
    end
    if (data_wr || skip_wr) begin
      stat_nxt.tx_empty_flag = 1'b0;
    end
    if (empty_set) begin
      stat_nxt.tx_empty_flag = 1'b1;
    end
    if (underrun_set) begin
      stat_nxt.tx_underrun_flag = 1'b1;
    end

    // Read data captured in the setup phase, presented in access
    if (i_psel && !i_penable) begin
      prdata_nxt = '0;
      unique case (i_paddr)
        TTM_OFF_CTRL: prdata_nxt[3:0] = ctrl_r;
        TTM_OFF_MASK: prdata_nxt[SLOTS-1:0] = mask_r;
        TTM_OFF_TXDATA: prdata_nxt[DATA_W-1:0] = data_r;
        TTM_OFF_STATUS: prdata_nxt[1:0] = stat_r;
        TTM_OFF_INTEN: prdata_nxt[1:0] = inten_r;
        TTM_OFF_WORD: prdata_nxt[TTM_WLEN_W-1:0] = wlen_r;
        default: prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= ttm_ctrl_s'(TTM_CTRL_RST);
      mask_r <= TTM_MASK_RST[SLOTS-1:0];
      data_r <= '0;
      inten_r <= TTM_INTEN_RST;
      wlen_r <= TTM_WLEN_RST;
      stat_r <= ttm_stat_s'(TTM_STAT_RST);
      prdata_r <= '0;
    end else if (i_clk_en) begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      data_r <= data_nxt;
      inten_r <= inten_nxt;
      wlen_r <= wlen_nxt;
      stat_r <= stat_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !reg_mapped(i_paddr);
  assign o_prdata = prdata_r;

  assign o_serial_tx_data_pin_o = sd_r;
  assign o_serial_tx_data_pin_oe = oe_r;
  assign o_irq = |(2'(stat_r) & inten_r);

endmodule : ttm_tx_slot_mask

`default_nettype wire

// *** ttm_tx_slot_mask_props.sv ***
// Port-level checks for the TDM transmit slot-mask block.
// Bound into the top module at the foot; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ttm_chk
  import ttm_pkg::*;
#(parameter int unsigned DATA_W = TTM_DATA_W, parameter int unsigned SLOTS = TTM_SLOTS) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Bus
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [TTM_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Link and interrupt
  input wire logic i_tx_bit_clock,
  input wire logic o_serial_tx_data_pin_o,
  input wire logic o_serial_tx_data_pin_oe,
  input wire logic o_irq
);
  // Cycles since the raw bit clock rose; design answers 2 to 3 later
  logic [3:0] since_r;
  logic [3:0] since_nxt;
  logic bclk_r;
  logic wr;
  assign wr = i_psel && i_penable && i_pwrite;
  always_comb begin
    since_nxt = since_r;
    if (i_tx_bit_clock && !bclk_r) since_nxt = 4'h0;
    else if (since_r != 4'hf) since_nxt = since_r + 4'h1;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      since_r <= 4'hf;
      bclk_r <= 1'b0;
    end else begin
      since_r <= since_nxt;
      bclk_r <= i_tx_bit_clock;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_ready_always: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low");
  a_unmapped_err: assert property (i_psel && i_penable && (i_paddr > 8'h1c
    || i_paddr[1:0] != 2'h0) |-> o_pslverr) else $error("no slave error");
  a_mapped_ok: assert property (i_psel && i_penable && i_paddr <= 8'h1c
    && i_paddr[1:0] == 2'h0 |-> !o_pslverr) else $error("stray slave error");
  a_wonly_zero: assert property (i_psel && i_penable && !i_pwrite && (i_paddr == TTM_OFF_SKIP
    || i_paddr == TTM_OFF_CLEAR) |-> o_prdata == 32'h0) else $error("read not zero");
  a_release_quiet: assert property ($rose(i_rst_n) |-> !o_serial_tx_data_pin_oe && !o_irq)
    else $error("active after reset");
  a_bit_holds: assert property (since_r >= 4'h6 && !$past(wr) |-> $stable(o_serial_tx_data_pin_o)
    && $stable(o_serial_tx_data_pin_oe)) else $error("pin moved mid bit");
  a_oe_at_edge: assert property ($changed(o_serial_tx_data_pin_oe) |->
    since_r inside {[1:5]} || $past(wr)) else $error("enable moved off edge");
  a_irq_cause: assert property ($rose(o_irq) |-> since_r inside {[1:6]} || $past(wr))
    else $error("irq without cause");
endmodule : ttm_chk
bind ttm_tx_slot_mask ttm_chk #(.DATA_W(DATA_W), .SLOTS(SLOTS)) u_ttm_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_tx_bit_clock(i_tx_bit_clock), .o_irq(o_irq),
  .o_serial_tx_data_pin_o(o_serial_tx_data_pin_o),
  .o_serial_tx_data_pin_oe(o_serial_tx_data_pin_oe));
`default_nettype wire

// *** ttm_link_model.sv ***
// Far side of the TDM line: bit clock, word-length frame sync, line level.
// Assumes the bench raises i_run for whole frames; clock stands still otherwise.
`timescale 1ns/1ps
`default_nettype none
module ttm_link_model #(parameter int NSL = 5, parameter int WB = 4) (
  // From the bench and the block
  input wire logic i_run,
  input wire logic i_oe,
  input wire logic i_d,
  // Link and position
  output logic o_bclk,
  output logic o_fsync,
  output logic [4:0] o_slot,
  output logic [3:0] o_bit,
  output logic o_line
);
  initial begin
    o_bclk = 1'b0;
    o_fsync = 1'b0;
    forever begin
      wait (i_run);
      // Offset keeps link edges clear of core clock edges
      #7;
      for (int s = 0; s < NSL; s++) begin
        for (int b = 0; b < WB; b++) begin
          o_slot = 5'(s);
          o_bit = 4'(b);
          o_fsync = (s == 0);
          #160 o_bclk = 1'b1;
          #160 o_bclk = 1'b0;
        end
      end
    end
  end
  // Released line shows the inverse, never a stale copy
  always @(i_oe or i_d) begin
    if (i_oe) o_line = i_d;
    else o_line = ~o_line;
  end
endmodule : ttm_link_model
`default_nettype wire

// *** ttm_tx_slot_mask_tb.sv ***
// Bench: APB traffic plus TDM frames, compared with a slot model.
// Needs the package, design, link model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module ttm_tx_slot_mask_tb;
  import ttm_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, run = 0;
  logic prdy, perr, err, bclk, fs, dout, doe, irq, line;
  logic edrv = 0, e_emp = 0, e_und = 0;
  logic [7:0] pa = 0;
  logic [31:0] pwd = 0, prd, rd, msk, txd;
  logic [4:0] slot;
  logic [3:0] bitn, pb, ew;
  logic [7:0] ra [8] = '{TTM_OFF_CTRL, TTM_OFF_MASK, TTM_OFF_STATUS, TTM_OFF_CLEAR,
    TTM_OFF_INTEN, TTM_OFF_WORD, TTM_OFF_SKIP, 8'h20};
  logic [31:0] rv [8] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0};
  int n_errors = 0, checked = 0, seed = 32'he1ec932b, last = 0, k, act;
  bit primed = 0;
  always #20 clk = ~clk;
  ttm_tx_slot_mask u_ttm_tx_slot_mask (.i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_tx_bit_clock(bclk),
    .i_tx_frame_sync(fs), .o_serial_tx_data_pin_o(dout), .o_serial_tx_data_pin_oe(doe),
    .o_irq(irq));
  ttm_link_model u_ttm_link_model (.i_run(run), .i_oe(doe), .i_d(dout), .o_bclk(bclk),
    .o_fsync(fs), .o_slot(slot), .o_bit(bitn), .o_line(line));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic tally_and_finish();
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // Previous bit checked at each rising link edge, before the block reacts
  always @(posedge bclk) begin
    if (primed) `CHK("oe", edrv, doe)
    if (primed && edrv) `CHK("bit", ew[3 - pb], line)
    if (bitn == 4'h0) begin
      edrv = 1'b0;
      if (msk[slot]) begin
        e_emp = 1'b1;
        e_und = e_und | (last == 0);
        edrv = (last != 2);
        ew = txd[3:0];
        last = 0;
      end
    end
    pb = bitn;
    primed = 1'b1;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 8; k++) begin
      apb(1'b0, ra[k], 32'h0);
      `CHK("reg", rv[k], rd)
      `CHK("err", k == 7, err)
    end
    txd = $random(seed);
    apb(1'b1, TTM_OFF_TXDATA, txd);
    last = 1;
    apb(1'b1, TTM_OFF_WORD, 32'h3);
    apb(1'b1, TTM_OFF_INTEN, 32'h1);
    apb(1'b1, TTM_OFF_CTRL, 32'h1);
    for (int c = 0; c < 2; c++) begin
      msk = c ? $random(seed) : 32'hffffffff;
      apb(1'b1, TTM_OFF_MASK, msk);
      run <= 1'b1;
      for (k = 0; k < 20; k++) begin
        @(posedge bclk iff bitn == 4'h1);
        apb(1'b0, TTM_OFF_STATUS, 32'h0);
        `CHK("status", {30'h0, e_und, e_emp}, rd)
        `CHK("irq", e_emp, irq)
        act = $unsigned($random(seed)) % 3;
        if (act == 1) txd = $random(seed);
        if (act > 0) begin
          apb(1'b1, act == 1 ? TTM_OFF_TXDATA : TTM_OFF_SKIP, txd);
          last = act;
          e_emp = 1'b0;
          @(posedge clk);
          `CHK("irq", 1'b0, irq)
        end
        if (e_und) apb(1'b1, TTM_OFF_CLEAR, 32'h2);
        e_und = 1'b0;
      end
      run <= 1'b0;
      repeat (60) @(posedge clk);
    end
    tally_and_finish();
  end
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
endmodule : ttm_tx_slot_mask_tb
`default_nettype wire
